// ==== inc/sadc_pkg.sv ====
// constants and types for the eight-channel converter control block
package sadc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int SADC_CHANNELS = 8;
    localparam int SADC_ADDR_W = 3;
    localparam int SADC_DATA_W = 8;
    localparam int SADC_CNT_W = 5;
    localparam int SADC_BIT_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // sequence lengths in conversion clock periods
    localparam int SADC_SAMPLE_CLKS = 32;
    localparam int SADC_BIT_CLKS = 4;
    localparam int SADC_ABORT_WINDOW_CLKS = 64;
    localparam logic [SADC_CNT_W-1:0] SADC_SAMPLE_LAST =
        SADC_CNT_W'(SADC_SAMPLE_CLKS - 1);
    localparam logic [SADC_CNT_W-1:0] SADC_BIT_LAST =
        SADC_CNT_W'(SADC_BIT_CLKS - 1);
    localparam logic [SADC_CNT_W-1:0] SADC_CNT_RST = 5'h00;

    ////////////////////////////////////////////////////////////////////////
    // done response bound: eight periods plus a fixed time
    localparam int SADC_CLK_PERIOD_NS = 5;
    localparam int SADC_EOC_BASE_CLKS = 8;
    localparam int SADC_EOC_EXTRA_NS = 2000;
    localparam int SADC_EOC_MAX_CLKS =
        SADC_EOC_BASE_CLKS + SADC_EOC_EXTRA_NS / SADC_CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // values after reset and trial weights
    localparam logic [SADC_DATA_W-1:0] SADC_RESULT_RST = 8'h00;
    localparam logic [SADC_DATA_W-1:0] SADC_MSB_WEIGHT = 8'h80;
    localparam logic [SADC_CHANNELS-1:0] SADC_CHAN_RST = 8'h01;
    localparam logic [SADC_CHANNELS-1:0] SADC_CHAN_ONE = 8'h01;
    localparam logic [SADC_BIT_W-1:0] SADC_MSB_IDX = 3'h7;
    localparam logic [SADC_BIT_W-1:0] SADC_LSB_IDX = 3'h0;
    localparam logic [SADC_BIT_W-1:0] SADC_BIT_STEP = 3'h1;
    localparam logic [SADC_CNT_W-1:0] SADC_CNT_STEP = 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // sequencer states
    typedef enum logic [1:0] {
        SADC_IDLE = 2'b00,
        SADC_SAMPLE = 2'b01,
        SADC_TRIAL = 2'b10
    } sadc_state_t;

endpackage

// ==== hw/sadc_ctrl.sv ====
// control and sequencing of the eight-channel converter
`timescale 1ns/1ps

module sadc_ctrl
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SADC_ADDR_W-1:0] addr,
    input wire logic addr_strobe,
    input wire logic conv_start,
    input wire logic out_en,
    input wire logic cmp_above,
    output logic [SADC_CHANNELS-1:0] chan_sel,
    output logic sample_sw,
    output logic [SADC_DATA_W-1:0] bit_trial_register,
    output logic [SADC_DATA_W-1:0] data_out,
    output logic data_oe,
    output logic conv_done
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SADC_ADDR_W-1:0] addr_s1_q;
    logic [SADC_ADDR_W-1:0] addr_s2_q;
    logic strobe_s1_q;
    logic strobe_s2_q;
    logic strobe_s3_q;
    logic start_s1_q;
    logic start_s2_q;
    logic start_s3_q;
    logic oe_s1_q;
    logic oe_s2_q;

    // address pins, two stages, qualified later by the strobe edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_s1_q <= 3'h0;
            addr_s2_q <= 3'h0;
        end else begin
            addr_s1_q <= addr;
            addr_s2_q <= addr_s1_q;
        end
    end

    // strobe pin, two stages against metastability
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_s1_q <= 1'b0;
            strobe_s2_q <= 1'b0;
        end else begin
            strobe_s1_q <= addr_strobe;
            strobe_s2_q <= strobe_s1_q;
        end
    end

    // strobe history, fed only from the settled stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_s3_q <= 1'b0;
        end else begin
            strobe_s3_q <= strobe_s2_q;
        end
    end

    // start pin, two stages; a fed-back done arrives here too
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_s1_q <= 1'b0;
            start_s2_q <= 1'b0;
        end else begin
            start_s1_q <= conv_start;
            start_s2_q <= start_s1_q;
        end
    end

    // start history for the edge detector
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_s3_q <= 1'b0;
        end else begin
            start_s3_q <= start_s2_q;
        end
    end

    // output enable pin, two stages
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_s1_q <= 1'b0;
            oe_s2_q <= 1'b0;
        end else begin
            oe_s1_q <= out_en;
            oe_s2_q <= oe_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // edge decode
    // rising edges seen on the settled stages only
    wire strobe_rise = strobe_s2_q & ~strobe_s3_q;
    // a start edge restarts from any state, fed-back done included
    wire start_rise = start_s2_q & ~start_s3_q;

    ////////////////////////////////////////////////////////////////////////
    // channel selection
    logic [SADC_CHANNELS-1:0] chan_sel_q;
    // straight binary decode, all-low is channel 0
    wire [SADC_CHANNELS-1:0] chan_dec = SADC_CHAN_ONE << addr_s2_q;
    // new selection only on a strobe edge
    wire [SADC_CHANNELS-1:0] chan_sel_d =
        strobe_rise ? chan_dec : chan_sel_q;

    // one-hot switch drive, exactly one channel on
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chan_sel_q <= SADC_CHAN_RST;
        end else begin
            chan_sel_q <= chan_sel_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    // phase, clock count and bit index
    sadc_state_t state_q;
    sadc_state_t state_d;
    logic [SADC_CNT_W-1:0] cnt_q;
    logic [SADC_BIT_W-1:0] bit_q;

    wire in_sample = (state_q == SADC_SAMPLE);
    wire in_trial = (state_q == SADC_TRIAL);

    // last clock of each phase and of the whole conversion
    wire sample_end = in_sample && (cnt_q == SADC_SAMPLE_LAST);
    wire bit_end = in_trial && (cnt_q == SADC_BIT_LAST);
    wire last_bit = (bit_q == SADC_LSB_IDX);
    wire conv_end = bit_end && last_bit;

    // start wins over every other step
    always_comb begin
        state_d = state_q;
        if (start_rise) begin
            state_d = SADC_SAMPLE;
        end else begin
            unique case (state_q)
                SADC_IDLE: begin
                    state_d = SADC_IDLE;
                end
                SADC_SAMPLE: begin
                    if (sample_end) begin
                        state_d = SADC_TRIAL;
                    end
                end
                SADC_TRIAL: begin
                    if (conv_end) begin
                        state_d = SADC_IDLE;
                    end
                end
                default: begin
                    state_d = SADC_IDLE;
                end
            endcase
        end
    end

    // counter restarts at each phase or bit boundary
    wire cnt_clear =
        start_rise | sample_end | bit_end | ~(in_sample | in_trial);
    wire [SADC_CNT_W-1:0] cnt_d =
        cnt_clear ? SADC_CNT_RST : cnt_q + SADC_CNT_STEP;

    // bit index walks msb to lsb, a restart reloads the msb
    wire [SADC_BIT_W-1:0] bit_d =
        start_rise ? SADC_MSB_IDX :
        bit_end ? bit_q - SADC_BIT_STEP : bit_q;

    // phase register, idle until the first start after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SADC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // clocks spent in the current phase or bit period
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= SADC_CNT_RST;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // index of the bit under trial
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_q <= SADC_MSB_IDX;
        end else begin
            bit_q <= bit_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bit trials
    logic [SADC_DATA_W-1:0] trial_q;
    // weight of the bit under trial, 128 first
    wire [SADC_BIT_W-1:0] bit_q_inv = SADC_MSB_IDX - bit_q;
    wire [SADC_DATA_W-1:0] weight = SADC_MSB_WEIGHT >> bit_q_inv;
    wire [SADC_DATA_W-1:0] next_weight = weight >> 1;
    // keep the weight when the node sits above trip point
    wire [SADC_DATA_W-1:0] decided =
        cmp_above ? trial_q : (trial_q & ~weight);
    wire [SADC_DATA_W-1:0] trial_d =
        start_rise ? SADC_RESULT_RST :
        sample_end ? SADC_MSB_WEIGHT :
        conv_end ? decided :
        bit_end ? (decided | next_weight) : trial_q;

    // trial pattern to the capacitor array
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            trial_q <= SADC_RESULT_RST;
        end else begin
            trial_q <= trial_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample switches and output latch
    logic sample_q;
    logic [SADC_DATA_W-1:0] data_q;
    logic done_q;
    logic oe_q;
    // start clears latch, finished conversion loads it
    wire [SADC_DATA_W-1:0] data_d =
        start_rise ? SADC_RESULT_RST :
        conv_end ? decided : data_q;

    // done drops on a start and rises with the latched result
    wire done_d = start_rise ? 1'b0 : (conv_end ? 1'b1 : done_q);

    // sampling switches closed for the whole sampling phase
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sample_q <= 1'b0;
        end else begin
            sample_q <= (state_d == SADC_SAMPLE);
        end
    end

    // result latch, steady until the next start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            data_q <= SADC_RESULT_RST;
        end else begin
            data_q <= data_d;
        end
    end

    // done flag, a start wins over a finishing conversion
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_d;
        end
    end

    // output enable, one stage behind the synchroniser
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= oe_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign chan_sel = chan_sel_q;
    assign sample_sw = sample_q;
    assign bit_trial_register = trial_q;
    assign data_out = data_q;
    assign data_oe = oe_q;
    assign conv_done = done_q;

endmodule

// ==== testbench/sadc_ctrl_assertions.sv ====
// assertion checker on the converter control block ports
`timescale 1ns/1ps
module sadc_chk
    import sadc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SADC_ADDR_W-1:0] addr,
    input wire logic addr_strobe,
    input wire logic conv_start,
    input wire logic out_en,
    input wire logic cmp_above,
    input wire logic [SADC_CHANNELS-1:0] chan_sel,
    input wire logic sample_sw,
    input wire logic [SADC_DATA_W-1:0] bit_trial_register,
    input wire logic [SADC_DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic conv_done
);
    localparam int EOC_MAX = SADC_EOC_MAX_CLKS;
    logic [6:0] samp_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // length of the current sampling run
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) samp_q <= 7'h00;
        else samp_q <= sample_sw ? samp_q + 7'h01 : 7'h00;
    end
    ////////////////////////////////////////////////////////////
    // sampling ends with no restart pending, then msb trial
    sequence s_trials_begin;
        $fell(sample_sw) ##0 !conv_start;
    endsequence
    sequence s_msb_first;
        bit_trial_register[7] ##4 bit_trial_register[6];
    endsequence
    a_sel_decode: assert property (
        $rose(addr_strobe) |-> ##[3:4] chan_sel == (SADC_CHAN_ONE << addr)
    ) else $error("channel select not decoded from address");
    a_sel_hold: assert property (
        $changed(chan_sel) |-> $past(addr_strobe, 3)
    ) else $error("channel select changed without strobe");
    a_start_clear: assert property (
        $rose(conv_start) |-> ##[1:EOC_MAX] !conv_done && data_out == 8'h00
    ) else $error("start did not clear done and result");
    a_sample_len: assert property (
        $fell(sample_sw) |-> samp_q >= 7'h20 && bit_trial_register == 8'h80
    ) else $error("sampling too short or first trial wrong");
    a_busy_low: assert property (
        $rose(sample_sw) |-> (!conv_done && data_out == 8'h00) [*8]
    ) else $error("done or result seen while sampling");
    a_msb_first: assert property (
        s_trials_begin |-> s_msb_first
    ) else $error("trial weights not from msb down");
    a_done_result: assert property (
        $rose(conv_done) |-> !sample_sw && data_out == bit_trial_register
    ) else $error("done without latched result");
    a_result_hold: assert property (
        conv_done && $past(conv_done) |-> $stable(data_out)
    ) else $error("result changed while done");
    a_sel_onehot: assert property (
        $onehot(chan_sel)
    ) else $error("channel select not one-hot");
    a_oe_follow: assert property (
        data_oe == $past(out_en, 3)
    ) else $error("output enable not following its pin");
endmodule
bind sadc_ctrl sadc_chk u_sadc_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
    .addr_strobe(addr_strobe), .conv_start(conv_start), .out_en(out_en),
    .cmp_above(cmp_above), .chan_sel(chan_sel), .sample_sw(sample_sw),
    .bit_trial_register(bit_trial_register), .data_out(data_out),
    .data_oe(data_oe), .conv_done(conv_done));

// ==== testbench/sadc_host_model.sv ====
// host and comparator model on the far side of the block
`timescale 1ns/1ps
module sadc_host_model
    import sadc_pkg::*;
(
    input wire logic [SADC_DATA_W-1:0] bit_trial_register,
    input wire logic [SADC_DATA_W-1:0] vin,
    input wire logic conv_done,
    input wire logic free_run,
    input wire logic start_req,
    output logic cmp_above,
    output logic conv_start
);
    // node above trip point while trial stays at or under input
    assign cmp_above = bit_trial_register <= vin;
    // done looped into start, host kick still needed first
    assign conv_start = start_req | (free_run & conv_done);
endmodule

// ==== testbench/sadc_ctrl_tb_top.sv ====
// self-checking testbench for the converter control block
`timescale 1ns/1ps
module sadc_ctrl_tb_top
    import sadc_pkg::*;
;
    logic clk, rst_b, addr_strobe, out_en, cmp_above, conv_start, sample_sw;
    logic data_oe, conv_done, free_run, start_req;
    logic [2:0] addr;
    logic [7:0] chan_sel, bit_trial_register, data_out, vin;
    int error_cnt, checked;
    sadc_ctrl u_sadc_ctrl (.clk(clk), .rst_b(rst_b), .addr(addr),
        .addr_strobe(addr_strobe), .conv_start(conv_start), .out_en(out_en),
        .cmp_above(cmp_above), .chan_sel(chan_sel), .sample_sw(sample_sw),
        .bit_trial_register(bit_trial_register), .data_out(data_out),
        .data_oe(data_oe), .conv_done(conv_done));
    sadc_host_model u_sadc_host_model (.bit_trial_register(bit_trial_register),
        .vin(vin), .conv_done(conv_done), .free_run(free_run),
        .start_req(start_req), .cmp_above(cmp_above), .conv_start(conv_start));
    ////////////////////////////////////////////////////////////
    // clock and shared helpers
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pulse_start();
        start_req <= 1'b1;
        cyc(3);
        start_req <= 1'b0;
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        @(negedge clk);
        while (conv_done !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk8({7'h00, conv_done}, 8'h01);
    endtask
    // one conversion, latch cleared then result of v
    task automatic conv(input logic [7:0] v);
        vin <= v;
        pulse_start();
        cyc(3);
        @(negedge clk);
        chk8({6'h00, conv_done, sample_sw}, 8'h01);
        chk8(data_out, 8'h00);
        wait_done();
        chk8(data_out, v);
        cyc(1);
    endtask
    // free running after one kick from the host
    task automatic t_free();
        vin <= 8'h81;
        free_run <= 1'b1;
        pulse_start();
        repeat (3) begin
            wait_done();
            chk8(data_out, 8'h81);
            cyc(8);
            chk8({6'h00, conv_done, sample_sw}, 8'h01);
        end
        free_run <= 1'b0;
        wait_done();
        cyc(1);
    endtask
    task automatic t_addr();
        for (int i = 0; i < 8; i++) begin
            addr <= 3'(i);
            cyc(10);
            addr_strobe <= 1'b1;
            cyc(3);
            addr_strobe <= 1'b0;
            cyc(10);
            chk8(chan_sel, SADC_CHAN_ONE << i);
        end
        addr <= 3'h2;
        cyc(10);
        chk8(chan_sel, 8'h80);
    endtask
    task automatic t_oe();
        out_en <= 1'b1;
        cyc(6);
        chk8({7'h00, data_oe}, 8'h01);
        out_en <= 1'b0;
        cyc(6);
        chk8({7'h00, data_oe}, 8'h00);
    endtask
    // restart in the bit phase discards the first result
    task automatic t_abort();
        vin <= 8'h3c;
        pulse_start();
        cyc(47);
        conv(8'hc3);
    endtask
    // reset in mid sampling, idle values, no self start afterwards
    task automatic t_reset();
        vin <= 8'h5a;
        pulse_start();
        cyc(10);
        rst_b <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk8(chan_sel, 8'h01);
        chk8({5'h00, sample_sw, data_oe, conv_done}, 8'h00);
        chk8(bit_trial_register, 8'h00);
        chk8(data_out, 8'h00);
        @(posedge clk);
        rst_b <= 1'b1;
        cyc(100);
        chk8({7'h00, conv_done}, 8'h00);
        conv(8'h5a);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // watchdog and main sequence
    initial begin
        cyc(5000);
        error_cnt++;
        results();
    end
    initial begin
        {rst_b, addr_strobe, out_en, start_req, free_run} = 5'h00;
        addr = 3'h0;
        vin = 8'h00;
        error_cnt = 0;
        checked = 0;
        cyc(20);
        rst_b <= 1'b1;
        cyc(1);
        t_free();
        foreach (vin[j]) conv(8'h01 << j ^ {8{j[0]}});
        conv(8'h00);
        conv(8'hff);
        t_addr();
        chk8(data_out, 8'hff);
        t_oe();
        t_abort();
        t_reset();
        results();
    end
endmodule
